// ==== hw/adc_ctrl.sv ====
// Converter control: registers, conversion sequencer and front-end drive
`timescale 1ns/100ps
`default_nettype none

module adc_ctrl
  import adc_ctrl_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  input wire logic [7:0] sec_addr,
  input wire logic sec_wr,
  input wire logic [7:0] sec_wdata,
  output logic [7:0] sec_rdata,
  input wire logic comp_hi_pin,
  output front_t front,
  output analog_cfg_t analog_cfg,
  output logic [43:0] pin_enable,
  output logic converter_pd,
  output logic oc_clk_en,
  output logic adc_irq
);

  logic [7:0] spt_ff;
  logic [5:0] chan_ff;
  logic start_ff;
  logic [7:0] ckc_ff;
  logic [11:0] result_ff;
  logic [6:0] pin0_ff;
  logic [7:0] pin_mid_ff [4];
  logic [4:0] pin5_ff;
  logic [7:0] pd_ff;
  logic [6:0] cfg_ff;
  logic [5:0] ext_ff;
  logic [7:0] sfr_rdata_ff;
  logic [7:0] sec_rdata_ff;
  logic comp_meta_ff;
  logic comp_sync_ff;
  logic oc_clk_en_ff;
  logic irq_ff;
  logic sample_en_ff;
  logic converting_ff;
  logic [5:0] cur_chan_ff;
  logic [1:0] lat_del_ff;
  logic [7:0] lat_spt_ff;
  logic [4:0] lat_gap_ff;
  conv_state_t state_ff;
  conv_state_t nxt_state;
  logic [10:0] ticks_ff;
  logic [10:0] cur_len;
  logic [10:0] samp_len;
  logic [10:0] gap_len;
  logic conv_tick;
  logic oc_tick;
  logic pd_now;
  logic start_go;
  logic phase_last;
  logic done;
  logic sar_load;
  logic sar_step;
  logic [11:0] sar_code;
  logic sfr_we_spt;
  logic sfr_we_scan;
  logic sfr_we_ckc;

  assign sfr_we_spt = sfr_wr && addr_hit(sfr_addr, SFR_SPT);
  assign sfr_we_scan = sfr_wr && addr_hit(sfr_addr, SFR_SCAN);
  assign sfr_we_ckc = sfr_wr && addr_hit(sfr_addr, SFR_CKC);
  assign pd_now = pd_ff[PD_CONV_BIT];

  // Software configuration registers
  always_ff @(posedge clk or posedge rst)
    if (rst)
      spt_ff <= RST_ZERO;
    else if (sfr_we_spt)
      spt_ff <= sfr_wdata;

  always_ff @(posedge clk or posedge rst)
    if (rst)
      chan_ff <= 6'h00;
    else if (sfr_we_scan)
      chan_ff <= sfr_wdata[SCAN_CHAN_LSB +: 6];

  always_ff @(posedge clk or posedge rst)
    if (rst)
      ckc_ff <= RST_ZERO;
    else if (sfr_we_ckc)
      ckc_ff <= sfr_wdata;

  always_ff @(posedge clk or posedge rst)
    if (rst)
      pin0_ff <= 7'h00;
    else if (sec_wr && addr_hit(sec_addr, SEC_PIN0))
      pin0_ff <= sec_wdata[6:0];

  genvar g;
  generate
    for (g = 0; g < 4; g++)
    begin : g_pin_mid
      always_ff @(posedge clk or posedge rst)
        if (rst)
          pin_mid_ff[g] <= RST_ZERO;
        else if (sec_wr && addr_hit(sec_addr, SEC_PIN1 + 8'(g)))
          pin_mid_ff[g] <= sec_wdata;
    end
  endgenerate

  always_ff @(posedge clk or posedge rst)
    if (rst)
      pin5_ff <= 5'h00;
    else if (sec_wr && addr_hit(sec_addr, SEC_PIN5))
      pin5_ff <= sec_wdata[4:0];

  // Other bits of this byte belong to neighbouring analog blocks; stored for readback
  always_ff @(posedge clk or posedge rst)
    if (rst)
      pd_ff <= RST_PD;
    else if (sec_wr && addr_hit(sec_addr, SEC_PD))
      pd_ff <= sec_wdata;

  always_ff @(posedge clk or posedge rst)
    if (rst)
      cfg_ff <= 7'h00;
    else if (sec_wr && addr_hit(sec_addr, SEC_CFG))
      cfg_ff <= sec_wdata[6:0];

  always_ff @(posedge clk or posedge rst)
    if (rst)
      ext_ff <= RST_EXT;
    else if (sec_wr && addr_hit(sec_addr, SEC_EXT))
      ext_ff <= sec_wdata[5:0];

  // Comparator crosses from the analog side
  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      comp_meta_ff <= 1'b0;
      comp_sync_ff <= 1'b0;
    end
    else
    begin
      comp_meta_ff <= comp_hi_pin;
      comp_sync_ff <= comp_meta_ff;
    end

  clk_enable_gen u_conv_tick (
    .clk(clk),
    .rst(rst),
    .rate(conv_rate(ckc_ff[CKC_CK_LSB +: 2])),
    .tick(conv_tick)
  );

  clk_enable_gen u_oc_tick (
    .clk(clk),
    .rst(rst),
    .rate(oc_rate(ckc_ff[CKC_CKV_LSB +: 2])),
    .tick(oc_tick)
  );

  always_ff @(posedge clk or posedge rst)
    if (rst)
      oc_clk_en_ff <= 1'b0;
    else
      oc_clk_en_ff <= oc_tick && !pd_now;

  // Start only from idle with the bit clear; a start bit written during a run is ignored, though the channel field still loads
  assign start_go = sfr_we_scan && sfr_wdata[SCAN_START_BIT] && !start_ff
    && state_ff == ST_IDLE && !pd_now;

  // Delay, sample and gap fields are frozen for the whole conversion; the converter clock select is not
  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      cur_chan_ff <= 6'h00;
      lat_del_ff <= 2'h0;
      lat_spt_ff <= RST_ZERO;
      lat_gap_ff <= 5'h00;
    end
    else if (start_go)
    begin
      cur_chan_ff <= sfr_wdata[SCAN_CHAN_LSB +: 6];
      lat_del_ff <= ckc_ff[CKC_DEL_LSB +: 2];
      lat_spt_ff <= spt_ff;
      lat_gap_ff <= cfg_ff[CFG_GAP_LSB +: 5];
    end

  assign samp_len = {1'b0, lat_spt_ff, 2'b00} + SAMPLE_MULT;
  assign gap_len = {6'h00, lat_gap_ff} + GAP_BASE;

  always_comb
  begin
    case (state_ff)
      ST_PRE: cur_len = presample_len(lat_del_ff);
      ST_SAMP: cur_len = samp_len;
      ST_GAP: cur_len = gap_len;
      ST_DECIDE: cur_len = DECIDE_TICKS;
      ST_TAIL: cur_len = TAIL_CYCLES;
      default: cur_len = 11'h000;
    endcase
  end

  // Tail counts system cycles; the other phases count converter periods
  assign phase_last = (state_ff == ST_TAIL) ? (ticks_ff == cur_len - 11'h001)
    : (conv_tick && ticks_ff == cur_len - 11'h001);

  always_comb
  begin
    nxt_state = state_ff;
    if (pd_now && state_ff != ST_IDLE)
      nxt_state = ST_IDLE;
    else
      case (state_ff)
        ST_IDLE:
          if (start_go)
            nxt_state = (presample_len(ckc_ff[CKC_DEL_LSB +: 2]) == 11'h000) ? ST_SAMP : ST_PRE;
        ST_PRE:
          if (phase_last)
            nxt_state = ST_SAMP;
        ST_SAMP:
          if (phase_last)
            nxt_state = ST_GAP;
        ST_GAP:
          if (phase_last)
            nxt_state = ST_DECIDE;
        ST_DECIDE:
          if (phase_last)
            nxt_state = ST_TAIL;
        ST_TAIL:
          if (phase_last)
            nxt_state = ST_IDLE;
        default:
          nxt_state = ST_IDLE;
      endcase
  end

  always_ff @(posedge clk or posedge rst)
    if (rst)
      state_ff <= ST_IDLE;
    else
      state_ff <= nxt_state;

  always_ff @(posedge clk or posedge rst)
    if (rst)
      ticks_ff <= 11'h000;
    else if (nxt_state != state_ff)
      ticks_ff <= 11'h000;
    else if (state_ff == ST_TAIL || (state_ff != ST_IDLE && conv_tick))
      ticks_ff <= ticks_ff + 11'h001;

  assign done = state_ff == ST_TAIL && phase_last && !pd_now;

  // Only twelve of the fourteen decision periods step the register
  assign sar_load = state_ff == ST_GAP && nxt_state == ST_DECIDE;
  assign sar_step = state_ff == ST_DECIDE && conv_tick && ticks_ff < RESULT_BITS;

  sar_engine u_sar (
    .clk(clk),
    .rst(rst),
    .load(sar_load),
    .step(sar_step),
    .comp_hi(comp_sync_ff),
    .code(sar_code)
  );

  always_ff @(posedge clk or posedge rst)
    if (rst)
      start_ff <= 1'b0;
    else if (done || (pd_now && state_ff != ST_IDLE))
      start_ff <= 1'b0;
    else if (start_go)
      start_ff <= 1'b1;

  always_ff @(posedge clk or posedge rst)
    if (rst)
      result_ff <= 12'h000;
    else if (done)
      result_ff <= sar_code;

  always_ff @(posedge clk or posedge rst)
    if (rst)
      irq_ff <= 1'b0;
    else
      irq_ff <= done;

  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      sample_en_ff <= 1'b0;
      converting_ff <= 1'b0;
    end
    else
    begin
      sample_en_ff <= nxt_state == ST_SAMP;
      converting_ff <= nxt_state != ST_IDLE;
    end

  // Reads have no side effects; data follow the address one cycle later
  always_ff @(posedge clk or posedge rst)
    if (rst)
      sfr_rdata_ff <= RST_ZERO;
    else
      case (sfr_addr)
        SFR_SPT: sfr_rdata_ff <= spt_ff;
        SFR_SCAN: sfr_rdata_ff <= {1'b0, chan_ff, start_ff};
        SFR_CKC: sfr_rdata_ff <= ckc_ff;
        SFR_RDH: sfr_rdata_ff <= {4'h0, result_ff[11:8]};
        SFR_RDL: sfr_rdata_ff <= result_ff[7:0];
        default: sfr_rdata_ff <= RST_ZERO;
      endcase

  always_ff @(posedge clk or posedge rst)
    if (rst)
      sec_rdata_ff <= RST_ZERO;
    else
      case (sec_addr)
        SEC_PIN0: sec_rdata_ff <= {1'b0, pin0_ff};
        SEC_PD: sec_rdata_ff <= pd_ff;
        SEC_CFG: sec_rdata_ff <= {1'b0, cfg_ff};
        SEC_EXT: sec_rdata_ff <= {2'h0, ext_ff};
        SEC_PIN1: sec_rdata_ff <= pin_mid_ff[0];
        SEC_PIN2: sec_rdata_ff <= pin_mid_ff[1];
        SEC_PIN3: sec_rdata_ff <= pin_mid_ff[2];
        SEC_PIN4: sec_rdata_ff <= pin_mid_ff[3];
        SEC_PIN5: sec_rdata_ff <= {3'h0, pin5_ff};
        default: sec_rdata_ff <= RST_ZERO;
      endcase

  assign sfr_rdata = sfr_rdata_ff;
  assign sec_rdata = sec_rdata_ff;
  assign front = '{sample_en: sample_en_ff, converting: converting_ff,
    channel: cur_chan_ff, dac_code: sar_code};
  assign analog_cfg = '{filter_en: ckc_ff[CKC_FILT_BIT], sample_gap_sel: ckc_ff[CKC_SAMBG_BIT],
    ref_sel: ext_ff[5], internal_reference_level_select: ext_ff[4],
    vref_chan_sel: ext_ff[3:2], offset_timing_sel: ext_ff[1:0], bias_sel: cfg_ff[1:0]};
  assign pin_enable = {pin5_ff, pin_mid_ff[3], pin_mid_ff[2], pin_mid_ff[1], pin_mid_ff[0],
    pin0_ff};
  assign converter_pd = pd_now;
  assign oc_clk_en = oc_clk_en_ff;
  assign adc_irq = irq_ff;

  sequence leave_pre;
    state_ff == ST_PRE && !pd_now ##1 state_ff == ST_SAMP;
  endsequence

  sequence leave_samp;
    state_ff == ST_SAMP && !pd_now ##1 state_ff == ST_GAP;
  endsequence

  sequence leave_gap;
    state_ff == ST_GAP && !pd_now ##1 state_ff == ST_DECIDE;
  endsequence

  sequence leave_decide;
    state_ff == ST_DECIDE && !pd_now ##1 state_ff == ST_TAIL;
  endsequence

  start_leaves_idle_a: assert property (@(posedge clk) disable iff (rst)
    start_go |=> converting_ff && start_ff && state_ff != ST_IDLE)
    else $error("start did not begin a conversion");

  done_loads_result_a: assert property (@(posedge clk) disable iff (rst)
    irq_ff |-> result_ff == $past(sar_code) && !start_ff)
    else $error("completion without result load");

  result_hold_a: assert property (@(posedge clk) disable iff (rst)
    $changed(result_ff) |-> irq_ff)
    else $error("result changed without completion");

  pre_length_a: assert property (@(posedge clk) disable iff (rst)
    leave_pre |-> $past(ticks_ff) == presample_len(lat_del_ff) - 11'h001)
    else $error("pre-sample delay length wrong");

  sample_length_a: assert property (@(posedge clk) disable iff (rst)
    leave_samp |-> $past(ticks_ff) == {1'b0, lat_spt_ff, 2'b00} + 11'h003)
    else $error("sampling length wrong");

  gap_length_a: assert property (@(posedge clk) disable iff (rst)
    leave_gap |-> $past(ticks_ff) == {6'h00, lat_gap_ff} + 11'h002)
    else $error("gap length wrong");

  decide_length_a: assert property (@(posedge clk) disable iff (rst)
    leave_decide |-> $past(ticks_ff) == 11'h00d)
    else $error("decision phase length wrong");

  tail_length_a: assert property (@(posedge clk) disable iff (rst || pd_now)
    $rose(state_ff == ST_TAIL) |-> (state_ff == ST_TAIL)[*5] ##1 state_ff == ST_IDLE ##0 irq_ff)
    else $error("tail length wrong");

  channel_held_a: assert property (@(posedge clk) disable iff (rst)
    converting_ff && $past(converting_ff) |-> $stable(front.channel))
    else $error("channel changed during conversion");

endmodule // adc_ctrl

`default_nettype wire

// ==== hw/adc_ctrl_pkg.sv ====
// Package: register map, field layout, timing and carrier types of the converter control
// Operation
// - A zero-to-one write of the start bit converts the selected channel once.
// - On completion the result registers load and an interrupt request pulses.
// - Twelve-bit successive approximation, single conversion only, no scan or continuous mode.
// - Result reads as upper nibble in low bits of one register, low byte another.
// - Six-bit channel field in bits 6..1; code 0x2c selects the internal reference.
// - Converter clock select gives 8, 6, 4 or 3 MHz for codes 0..3.
// - Offset-cancel clock select gives 12, 8, 4 or 2 MHz for codes 0..3.
// - Conversion runs pre-delay, sampling, gap, bit decision and a 200 ns tail.
// - Pre-sample delay lasts the number of converter periods chosen by its field.
// - Sampling lasts four times sample setting plus one converter periods.
// - Gap after sampling lasts three plus the gap setting converter periods.
// - Bit decision lasts fourteen converter periods: twelve bits plus two.
// - Result is linear: 4096 codes span the selected reference voltage.
// - Hardware clears the start bit at the end; the interrupt flag is software cleared (here adc_irq is a one-cycle pulse with no flag to clear).
// - Pre-sample delay codes 0..3 give 0, 2, 4 or 8 converter periods.
// - Converter power-down bit disables the converter when one; resets to one.
// - Each analog pin enable bit connects one channel pin to the converter.
`default_nettype none

package adc_ctrl_pkg;

  // Special function register offsets
  localparam logic [7:0] SFR_SPT = 8'hc1;
  localparam logic [7:0] SFR_SCAN = 8'hc3;
  localparam logic [7:0] SFR_CKC = 8'hc4;
  localparam logic [7:0] SFR_RDH = 8'hc5;
  localparam logic [7:0] SFR_RDL = 8'hc6;

  // Secondary bus register offsets
  localparam logic [7:0] SEC_PIN0 = 8'h2a;
  localparam logic [7:0] SEC_PD = 8'h2d;
  localparam logic [7:0] SEC_CFG = 8'h32;
  localparam logic [7:0] SEC_EXT = 8'h42;
  localparam logic [7:0] SEC_PIN1 = 8'h53;
  localparam logic [7:0] SEC_PIN2 = 8'h54;
  localparam logic [7:0] SEC_PIN3 = 8'h55;
  localparam logic [7:0] SEC_PIN4 = 8'h56;
  localparam logic [7:0] SEC_PIN5 = 8'h57;

  // Reset values
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_PD = 8'hff;
  localparam logic [5:0] RST_EXT = 6'h02;

  // Field positions
  localparam int SCAN_START_BIT = 0;
  localparam int SCAN_CHAN_LSB = 1;
  localparam int CKC_CK_LSB = 0;
  localparam int CKC_CKV_LSB = 2;
  localparam int CKC_DEL_LSB = 4;
  localparam int CKC_SAMBG_BIT = 6;
  localparam int CKC_FILT_BIT = 7;
  localparam int CFG_GAP_LSB = 2;
  localparam int PD_CONV_BIT = 0;
  localparam logic [5:0] CHAN_REF = 6'h2c;

  // Timing
  localparam logic [5:0] SYS_CLK_MHZ = 6'h19;
  localparam int SYS_PERIOD_NS = 40;
  localparam int TAIL_NS = 200;
  localparam logic [10:0] TAIL_CYCLES = 11'((TAIL_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS);
  localparam logic [10:0] SAMPLE_MULT = 11'h004;
  localparam logic [10:0] GAP_BASE = 11'h003;
  localparam logic [10:0] DECIDE_TICKS = 11'h00e;
  localparam logic [10:0] RESULT_BITS = 11'h00c;
  localparam logic [11:0] SAR_MSB = 12'h800;

  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_PRE = 6'h02,
    ST_SAMP = 6'h04,
    ST_GAP = 6'h08,
    ST_DECIDE = 6'h10,
    ST_TAIL = 6'h20
  } conv_state_t;

  typedef struct packed {
    logic sample_en;
    logic converting;
    logic [5:0] channel;
    logic [11:0] dac_code;
  } front_t;

  typedef struct packed {
    logic filter_en;
    logic sample_gap_sel;
    logic ref_sel;
    logic internal_reference_level_select;
    logic [1:0] vref_chan_sel;
    logic [1:0] offset_timing_sel;
    logic [1:0] bias_sel;
  } analog_cfg_t;

  function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] b);
    return a == b;
  endfunction

  // Rates in MHz; the divider spreads ticks evenly over the 25 MHz clock
  function automatic logic [4:0] conv_rate(input logic [1:0] sel);
    case (sel)
      2'h0: return 5'h08;
      2'h1: return 5'h06;
      2'h2: return 5'h04;
      default: return 5'h03;
    endcase
  endfunction

  function automatic logic [4:0] oc_rate(input logic [1:0] sel);
    case (sel)
      2'h0: return 5'h0c;
      2'h1: return 5'h08;
      2'h2: return 5'h04;
      default: return 5'h02;
    endcase
  endfunction

  function automatic logic [10:0] presample_len(input logic [1:0] sel);
    case (sel)
      2'h0: return 11'h000;
      2'h1: return 11'h002;
      2'h2: return 11'h004;
      default: return 11'h008;
    endcase
  endfunction

endpackage

`default_nettype wire

// ==== hw/clk_enable_gen.sv ====
// Fractional divider producing an enable pulse at a chosen rate in MHz
`timescale 1ns/100ps
`default_nettype none

module clk_enable_gen
  import adc_ctrl_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [4:0] rate,
  output logic tick
);

  logic [4:0] acc_ff;
  logic tick_ff;
  logic [5:0] sum;

  // Average rate is exact; single ticks jitter by one system cycle
  assign sum = {1'b0, acc_ff} + {1'b0, rate};

  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      acc_ff <= 5'h00;
      tick_ff <= 1'b0;
    end
    else if (sum >= SYS_CLK_MHZ)
    begin
      acc_ff <= 5'(sum - SYS_CLK_MHZ);
      tick_ff <= 1'b1;
    end
    else
    begin
      acc_ff <= sum[4:0];
      tick_ff <= 1'b0;
    end

  assign tick = tick_ff;

endmodule // clk_enable_gen

`default_nettype wire

// ==== hw/sar_engine.sv ====
// Successive approximation register: one bit decided per step
`timescale 1ns/100ps
`default_nettype none

module sar_engine
  import adc_ctrl_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic load,
  input wire logic step,
  input wire logic comp_hi,
  output logic [11:0] code
);

  logic [11:0] code_ff;
  logic [11:0] mask_ff;

  // Binary weighted trial, MSB first, so the code is linear in the reference
  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      code_ff <= 12'h000;
      mask_ff <= 12'h000;
    end
    else if (load)
    begin
      code_ff <= SAR_MSB;
      mask_ff <= SAR_MSB;
    end
    else if (step && mask_ff != 12'h000)
    begin
      code_ff <= (comp_hi ? code_ff : (code_ff & ~mask_ff)) | (mask_ff >> 1);
      mask_ff <= mask_ff >> 1;
    end

  assign code = code_ff;

endmodule // sar_engine

`default_nettype wire

// ==== testbench/comp_front_model.sv ====
// Comparator front-end model: answers each trial code against a held input level
`timescale 1ns/100ps
`default_nettype none

module comp_front_model
  import adc_ctrl_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire front_t front,
  input wire logic [11:0] level,
  output logic comp_hi
);
  logic wander_ff;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      wander_ff <= 1'b0;
    else
      wander_ff <= ~wander_ff;
  end

  // Outside a conversion the comparator means nothing, so its output wanders
  assign comp_hi = front.converting ? (level >= front.dac_code) : wander_ff;

endmodule // comp_front_model

`default_nettype wire

// ==== testbench/sar_adc_conversion_control_test.sv ====
// Self-checking bench of the converter control with a comparator model
`timescale 1ns/100ps
`default_nettype none

module sar_adc_conversion_control_test;
  import adc_ctrl_pkg::*;

  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] sfr_addr = 8'h00;
  logic sfr_wr = 1'b0;
  logic [7:0] sfr_wdata = 8'h00;
  logic [7:0] sec_addr = 8'h00;
  logic sec_wr = 1'b0;
  logic [7:0] sec_wdata = 8'h00;
  logic [7:0] sfr_rdata;
  logic [7:0] sec_rdata;
  logic comp_hi;
  logic [11:0] level = 12'h000;
  front_t front;
  analog_cfg_t analog_cfg;
  logic [43:0] pin_enable;
  logic converter_pd;
  logic oc_clk_en;
  logic adc_irq;
  int err_count = 0;
  int cmp_count = 0;
  int cyc = 0;
  int seed = 4179;
  int cnt;
  logic [11:0] q [$];
  logic [11:0] last;
  logic [7:0] pd [6];
  logic [7:0] pa [6] = '{8'h2a, 8'h53, 8'h54, 8'h55, 8'h56, 8'h57};
  int rate [4] = '{8, 6, 4, 3};
  int ocr [4] = '{12, 8, 4, 2};

  adc_ctrl dut (.clk(clk), .rst(rst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .sec_addr(sec_addr), .sec_wr(sec_wr),
    .sec_wdata(sec_wdata), .sec_rdata(sec_rdata), .comp_hi_pin(comp_hi), .front(front),
    .analog_cfg(analog_cfg), .pin_enable(pin_enable), .converter_pd(converter_pd),
    .oc_clk_en(oc_clk_en), .adc_irq(adc_irq));

  comp_front_model partner (.clk(clk), .rst(rst), .front(front), .level(level),
    .comp_hi(comp_hi));

  always #20 clk = ~clk;

  task automatic end_sim();
    if (err_count == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Generous ceiling: the longest conversion is a few thousand cycles
  always @(posedge clk)
  begin
    cyc++;
    if (cyc > 60000)
    begin
      err_count++;
      end_sim();
    end
  end

  task automatic chk(input logic [11:0] g, input logic [11:0] e);
    cmp_count++;
    if (g !== e)
    begin
      err_count++;
      $display("[FAIL] %0t got %h expected %h", $time, g, e);
    end
  endtask

  task automatic wr(input logic sec, input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    sfr_addr = a;
    sec_addr = a;
    sfr_wdata = d;
    sec_wdata = d;
    sfr_wr = ~sec;
    sec_wr = sec;
    @(negedge clk);
    sfr_wr = 1'b0;
    sec_wr = 1'b0;
  endtask

  // Read data is registered, so it is looked at one cycle after the address
  task automatic rd(input logic sec, input logic [7:0] a, input logic [7:0] e);
    @(negedge clk);
    sfr_addr = a;
    sec_addr = a;
    @(negedge clk);
    chk({4'h0, sec ? sec_rdata : sfr_rdata}, {4'h0, e});
  endtask

  task automatic conv(input logic [5:0] ch, input logic [7:0] spt, input logic [1:0] k,
    input logic [4:0] gap);
    int n;
    int ticks;
    int ex;
    int tol;
    level = 12'($random(seed));
    q.push_back(level);
    wr(0, SFR_SPT, spt);
    // Offset-cancel clock kept at its fastest so the gap always covers four of its periods
    wr(0, SFR_CKC, {2'h0, k, 2'h0, k});
    wr(1, SEC_CFG, {1'h0, gap, 2'h0});
    wr(0, SFR_SCAN, {1'h0, ch, 1'h1});
    chk({11'h0, front.converting}, 12'h001);
    chk({6'h0, front.channel}, {6'h0, ch});
    chk({11'h0, front.sample_en}, {11'h0, k == 2'h0});
    ticks = (k == 0 ? 0 : 1 << k) + 4 * (spt + 1) + 3 + gap + 14;
    ex = ticks * 25 / rate[k] + TAIL_NS / SYS_PERIOD_NS;
    tol = 25 / rate[k] + 3;
    n = 0;
    while (adc_irq !== 1'b1 && n < 12000)
    begin
      @(negedge clk);
      n++;
    end
    chk({11'h0, n >= ex - tol && n <= ex + tol}, 12'h001);
    @(negedge clk);
    chk({11'h0, adc_irq}, 12'h000);
    last = q.pop_front();
    rd(0, SFR_RDH, {4'h0, last[11:8]});
    rd(0, SFR_RDL, last[7:0]);
    rd(0, SFR_SCAN, {1'h0, ch, 1'h0});
  endtask

  initial
  begin
    repeat (8) @(negedge clk);
    rst = 1'b0;
    for (int i = 0; i < 6; i++)
      rd(0, 8'hc1 + 8'(i), RST_ZERO);
    rd(0, 8'h00, RST_ZERO);
    rd(1, SEC_PIN0, RST_ZERO);
    rd(1, SEC_PD, RST_PD);
    rd(1, SEC_CFG, RST_ZERO);
    rd(1, SEC_EXT, {2'h0, RST_EXT});
    chk({11'h0, converter_pd}, 12'h001);
    for (int i = 0; i < 6; i++)
    begin
      pd[i] = 8'($random(seed));
      wr(1, pa[i], pd[i]);
    end
    @(negedge clk);
    chk(pin_enable[11:0], {pd[1][4:0], pd[0][6:0]});
    chk(pin_enable[43:32], {pd[5][4:0], pd[4][7:1]});
    chk(pin_enable[31:20], {pd[4][0], pd[3], pd[2][7:5]});
    chk({4'h0, pin_enable[19:12]}, {4'h0, pd[2][4:0], pd[1][7:5]});
    wr(1, SEC_PD, 8'h00);
    chk({11'h0, converter_pd}, 12'h000);
    for (int k = 0; k < 4; k++)
    begin
      wr(0, SFR_CKC, {4'h0, 2'(k), 2'h0});
      cnt = 0;
      // 250 cycles of 40 ns give ten pulses per MHz, give or take one for divider phase
      for (int i = 0; i < 250; i++)
      begin
        @(negedge clk);
        if (oc_clk_en === 1'b1)
          cnt++;
      end
      chk({11'h0, cnt >= ocr[k] * 10 - 1 && cnt <= ocr[k] * 10 + 1}, 12'h001);
    end
    for (int k = 0; k < 4; k++)
    begin
      if (k == 3)
        wr(1, SEC_EXT, 8'h32);
      conv(k == 3 ? CHAN_REF : 6'(($random(seed) & 32'h7fff) % 44), 8'($random(seed)) & 8'h0f,
        2'(k), 5'($random(seed)));
    end
    chk({11'h0, analog_cfg.ref_sel}, 12'h001);
    chk({11'h0, analog_cfg.internal_reference_level_select}, 12'h001);
    conv(6'h2b, 8'hff, 2'h0, 5'h1f);
    wr(0, SFR_CKC, 8'h00);
    wr(0, SFR_SCAN, 8'h03);
    repeat (20) @(negedge clk);
    wr(1, SEC_PD, 8'h01);
    // The abort is seen by the sequencer one cycle after the power-down bit lands
    @(negedge clk);
    chk({11'h0, front.converting}, 12'h000);
    wr(0, SFR_SCAN, 8'h03);
    chk({11'h0, front.converting}, 12'h000);
    for (int i = 0; i < 400; i++)
    begin
      @(negedge clk);
      if (adc_irq === 1'b1)
        chk(12'h001, 12'h000);
    end
    rd(0, SFR_RDH, {4'h0, last[11:8]});
    rd(0, SFR_RDL, last[7:0]);
    rd(0, SFR_SCAN, 8'h02);
    end_sim();
  end

endmodule // sar_adc_conversion_control_test

`default_nettype wire
